// [can_cap_pkg.sv]
// ----------------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------------
package can_cap_pkg;
    localparam int         ADDR_W        = 4;
    localparam logic [3:0] STATUS_OFS    = 4'h0;
    localparam logic [3:0] CTRL_OFS      = 4'h4;
    localparam logic [3:0] TEC_OFS       = 4'h8;
    localparam logic [3:0] REC_OFS       = 4'hc;
    localparam int         CAP_W         = 8;
    localparam int         CNT_WIDTH     = 8;
    localparam int         ERR_LSB       = 0;
    localparam int         ARB_LSB       = 8;
    localparam int         ERR_FRESH_BIT = 16;
    localparam int         ARB_FRESH_BIT = 17;
    localparam int         CTRL_COMM_BIT = 0;
    localparam int         SEGMENT_W     = 5;
    localparam int         CLASS_W       = 2;
    localparam int         LOST_W        = 5;
    localparam int         PAD_W         = CAP_W - LOST_W;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam logic       DIR_TX        = 1'h0;
    localparam logic       DIR_RX        = 1'h1;
    localparam logic [4:0] SEGMENT_NONE  = 5'h00;
    localparam logic [1:0] CLASS_BIT     = 2'h0;
    localparam logic [1:0] CLASS_FORM    = 2'h1;
    localparam logic [1:0] CLASS_STUFF   = 2'h2;
    localparam logic [1:0] CLASS_OTHER   = 2'h3;
    localparam logic [7:0] CAP_CLEAR     = 8'h00;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    typedef enum logic {WR_COLLECT, WR_RESP} wr_state_type;
endpackage

// [cap_if.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Carrier between the top and one capture slot
// ----------------------------------------------------------------------
interface cap_if #(parameter int W = 8);
    logic         ev;
    logic [W-1:0] ev_data;
    logic         start;
    logic         rearm;
    logic [W-1:0] data;
    logic         fresh;
    modport ctrl (output ev, ev_data, start, rearm, input data, fresh);
    modport slot (input ev, ev_data, start, rearm, output data, fresh);
endinterface

// [cap_slot.sv]
`timescale 1ns/100ps
module cap_slot
    import can_cap_pkg::*;
#(
    parameter int W = CAP_W
)
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic ce,
    cap_if.slot       port
);
    logic         armed_q;
    logic         armed_d;
    logic         fresh_q;
    logic         fresh_d;
    logic [W-1:0] data_q;
    logic [W-1:0] data_d;

    // A read and an event in the same cycle: the event is kept.
    always_comb
    begin
        armed_d = armed_q;
        fresh_d = fresh_q;
        data_d  = data_q;
        if (port.start)
        begin
            armed_d = 1'b1;
            fresh_d = 1'b0;
            data_d  = '0;
        end
        else
        begin
            if (port.rearm)
            begin
                armed_d = 1'b1;
                fresh_d = 1'b0;
            end
            if (port.ev && (armed_q || port.rearm))
            begin
                armed_d = 1'b0;
                fresh_d = 1'b1;
                data_d  = port.ev_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            armed_q <= 1'b1;
            fresh_q <= 1'b0;
            data_q  <= '0;
        end
        else if (ce)
        begin
            armed_q <= armed_d;
            fresh_q <= fresh_d;
            data_q  <= data_d;
        end
    end

    assign port.data  = data_q;
    assign port.fresh = fresh_q;

    property p_hold;
        @(posedge mclk) disable iff (!rst_b)
        (!armed_q && !port.rearm && !port.start) |=> $stable(data_q) && fresh_q;
    endproperty
    a_hold: assert property (p_hold) else $error("capture changed while held");

    property p_take;
        @(posedge mclk) disable iff (!rst_b)
        (ce && port.ev && armed_q && !port.start) |=> (data_q == $past(port.ev_data)) && fresh_q;
    endproperty
    a_take: assert property (p_take) else $error("armed capture missed an event");
endmodule

// [err_counter.sv]
`timescale 1ns/100ps
module err_counter
    import can_cap_pkg::*;
#(
    parameter int W = CNT_WIDTH
)
(
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic         inc,
    output logic      [W-1:0] cnt
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Saturates rather than wrapping so a flooded bus never reads as quiet.
    always_comb
    begin
        cnt_d = cnt_q;
        if (inc && (cnt_q != '1))
        begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
        end
        else if (ce)
        begin
            cnt_q <= cnt_d;
        end
    end

    assign cnt = cnt_q;
endmodule

// [can_error_arb_capture.sv]
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Functional notes
// - First bus error after start is held until status read, then re-armed.
// - First arbitration loss position is held until status read, then re-armed.
// - Each bus error while communication is enabled bumps the transmit or receive counter by direction.
// - Arbitration loss touches neither counter nor error capture.
// - Each capture has a fresh flag: set on new data, cleared by read.
// - Error capture byte sits in status bits 7 to 0.
// - Arbitration capture byte sits in status bits 15 to 8.
// - Error fresh flag sits at status bit 16.
// - Arbitration fresh flag sits at status bit 17.
// - Segment code zero means no error recorded.
// - Segment codes 2 to 15 name frame segments.
// - Segment codes 17 to 28 name error and framing phases.
// - Direction is 0 when transmitting, 1 when receiving.
// - Class is 0 bit, 1 form, 2 stuff, 3 other.
// - Lost position counts arbitration bits from the first identifier bit.
// - Before the first error after start all error fields read zero.
// ----------------------------------------------------------------------
module can_error_arb_capture
    import can_cap_pkg::*;
#(
    parameter int CNT_W = CNT_WIDTH
)
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              bus_err,
    input  wire logic [SEGMENT_W-1:0] error_segment_code,
    input  wire logic [CLASS_W-1:0] error_class,
    input  wire logic              transmitting,
    input  wire logic              arb_lost,
    input  wire logic [LOST_W-1:0] lost_bit_position,
    output logic      [CNT_W-1:0]  tx_err_cnt,
    output logic      [CNT_W-1:0]  rx_err_cnt,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cap_if #(.W(CAP_W)) err_if ();
    cap_if #(.W(CAP_W)) arb_if ();

    wr_state_type      wr_state_q;
    wr_state_type      wr_state_d;
    logic              awready_q;
    logic              awready_d;
    logic              wready_q;
    logic              wready_d;
    logic              have_aw_q;
    logic              have_aw_d;
    logic              have_w_q;
    logic              have_w_d;
    logic [ADDR_W-1:0] waddr_q;
    logic [ADDR_W-1:0] waddr_d;
    logic [31:0]       wdata_q;
    logic [31:0]       wdata_d;
    logic              wstrb0_q;
    logic              wstrb0_d;
    logic              bvalid_q;
    logic              bvalid_d;
    logic [1:0]        bresp_q;
    logic [1:0]        bresp_d;
    logic              comm_q;
    logic              comm_d;
    logic              start;
    logic              arready_q;
    logic              arready_d;
    logic              rvalid_q;
    logic              rvalid_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic [1:0]        rresp_q;
    logic [1:0]        rresp_d;
    logic              status_rd;
    logic              err_take;
    logic [31:0]       status_word;

    // ------------------------------------------------------------------
    // Capture sources
    // ------------------------------------------------------------------
    // Events count only while communication is enabled.
    assign err_take = comm_q && bus_err;

    assign err_if.ev      = err_take;
    assign err_if.ev_data = {error_class,
                             transmitting ? DIR_TX : DIR_RX,
                             error_segment_code};
    assign err_if.start   = start;
    assign err_if.rearm   = status_rd;

    // An arbitration loss has its own slot and never reaches the error one.
    assign arb_if.ev      = comm_q && arb_lost;
    assign arb_if.ev_data = {PAD_W'(0), lost_bit_position};
    assign arb_if.start   = start;
    assign arb_if.rearm   = status_rd;

    cap_slot #(.W(CAP_W)) u_err_cap (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .port  (err_if.slot)
    );

    cap_slot #(.W(CAP_W)) u_arb_cap (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .port  (arb_if.slot)
    );

    err_counter #(.W(CNT_W)) u_tec (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .inc   (err_take && transmitting),
        .cnt   (tx_err_cnt)
    );

    err_counter #(.W(CNT_W)) u_rec (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .inc   (err_take && !transmitting),
        .cnt   (rx_err_cnt)
    );

    always_comb
    begin
        status_word                                   = WORD_ZERO;
        status_word[ERR_LSB +: CAP_W]                 = err_if.data;
        status_word[ARB_LSB +: CAP_W]                 = arb_if.data;
        status_word[ERR_FRESH_BIT]                    = err_if.fresh;
        status_word[ARB_FRESH_BIT]                    = arb_if.fresh;
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    always_comb
    begin
        wr_state_d = wr_state_q;
        awready_d  = awready_q;
        wready_d   = wready_q;
        have_aw_d  = have_aw_q;
        have_w_d   = have_w_q;
        waddr_d    = waddr_q;
        wdata_d    = wdata_q;
        wstrb0_d   = wstrb0_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        comm_d     = comm_q;
        start      = 1'b0;
        case (wr_state_q)
            WR_COLLECT:
            begin
                if (s_axi_awvalid && awready_q)
                begin
                    have_aw_d = 1'b1;
                    awready_d = 1'b0;
                    waddr_d   = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q)
                begin
                    have_w_d = 1'b1;
                    wready_d = 1'b0;
                    wdata_d  = s_axi_wdata;
                    wstrb0_d = s_axi_wstrb[0];
                end
                if (have_aw_q && have_w_q)
                begin
                    have_aw_d  = 1'b0;
                    have_w_d   = 1'b0;
                    bvalid_d   = 1'b1;
                    wr_state_d = WR_RESP;
                    bresp_d    = RESP_OKAY;
                    if (waddr_q == CTRL_OFS)
                    begin
                        if (wstrb0_q)
                        begin
                            comm_d = wdata_q[CTRL_COMM_BIT];
                            // Enabling afresh clears both captures.
                            start  = wdata_q[CTRL_COMM_BIT] && !comm_q;
                        end
                    end
                    else if ((waddr_q != STATUS_OFS) && (waddr_q != TEC_OFS) && (waddr_q != REC_OFS))
                    begin
                        bresp_d = RESP_SLVERR;
                    end
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    bvalid_d   = 1'b0;
                    awready_d  = 1'b1;
                    wready_d   = 1'b1;
                    wr_state_d = WR_COLLECT;
                end
            end
            default:
            begin
                wr_state_d = WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_state_q <= WR_COLLECT;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            have_aw_q  <= 1'b0;
            have_w_q   <= 1'b0;
            waddr_q    <= '0;
            wdata_q    <= WORD_ZERO;
            wstrb0_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
            comm_q     <= 1'b0;
        end
        else if (ce)
        begin
            wr_state_q <= wr_state_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            have_aw_q  <= have_aw_d;
            have_w_q   <= have_w_d;
            waddr_q    <= waddr_d;
            wdata_q    <= wdata_d;
            wstrb0_q   <= wstrb0_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            comm_q     <= comm_d;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // The word is sampled in the cycle that re-arms, so nothing slips between.
    always_comb
    begin
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        status_rd = 1'b0;
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = RESP_OKAY;
            rdata_d   = WORD_ZERO;
            case (s_axi_araddr)
                STATUS_OFS:
                begin
                    rdata_d   = status_word;
                    status_rd = 1'b1;
                end
                CTRL_OFS: rdata_d[CTRL_COMM_BIT] = comm_q;
                TEC_OFS:  rdata_d[CNT_W-1:0] = tx_err_cnt;
                REC_OFS:  rdata_d[CNT_W-1:0] = rx_err_cnt;
                default:  rresp_d = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= WORD_ZERO;
            rresp_q   <= RESP_OKAY;
        end
        else if (ce)
        begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_tx_count;
        @(posedge mclk) disable iff (!rst_b)
        (ce && err_take && transmitting && (tx_err_cnt != '1)) |=> tx_err_cnt == $past(tx_err_cnt) + CNT_W'(1);
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("transmit error not counted");

    property p_arb_quiet;
        @(posedge mclk) disable iff (!rst_b)
        (arb_lost && !bus_err) |=> $stable(tx_err_cnt) && $stable(rx_err_cnt);
    endproperty
    a_arb_quiet: assert property (p_arb_quiet) else $error("arbitration loss moved a counter");

    property p_low_bytes;
        @(posedge mclk) disable iff (!rst_b)
        (ce && status_rd) |=> (rdata_q[ERR_LSB +: CAP_W] == $past(err_if.data))
            && (rdata_q[ARB_LSB +: CAP_W] == $past(arb_if.data));
    endproperty
    a_low_bytes: assert property (p_low_bytes) else $error("capture bytes misplaced");

    property p_fresh_bits;
        @(posedge mclk) disable iff (!rst_b)
        (ce && status_rd) |=> (rdata_q[ERR_FRESH_BIT] == $past(err_if.fresh))
            && (rdata_q[ARB_FRESH_BIT] == $past(arb_if.fresh));
    endproperty
    a_fresh_bits: assert property (p_fresh_bits) else $error("fresh flags misplaced");

    property p_rearm;
        @(posedge mclk) disable iff (!rst_b)
        (ce && status_rd && !bus_err && !arb_lost && !start) |=> !err_if.fresh && !arb_if.fresh;
    endproperty
    a_rearm: assert property (p_rearm) else $error("read left a fresh flag set");

    property p_start_zero;
        @(posedge mclk) disable iff (!rst_b)
        (ce && start) |=> (err_if.data == CAP_CLEAR) && !err_if.fresh;
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("error capture not cleared at start");
endmodule

// [can_bus_node.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Far-side node model: raises bus error and arbitration loss events
// ----------------------------------------------------------------------
module can_bus_node
(
    input  wire logic       mclk,
    output logic            bus_err,
    output logic [4:0]      error_segment_code,
    output logic [1:0]      error_class,
    output logic            transmitting,
    output logic            arb_lost,
    output logic [4:0]      lost_bit_position
);
    initial
    begin
        bus_err = 1'b0;
        arb_lost = 1'b0;
        error_segment_code = 5'h00;
        error_class = 2'h0;
        transmitting = 1'b0;
        lost_bit_position = 5'h00;
    end
    // Code, class and lost position are inverted once the pulse ends so a stale value is never mistaken for valid data; transmitting is left as driven.
    task automatic send_err(input logic [4:0] code, input logic [1:0] cls, input logic tx);
        @(posedge mclk);
        bus_err <= 1'b1;
        error_segment_code <= code;
        error_class <= cls;
        transmitting <= tx;
        @(posedge mclk);
        bus_err <= 1'b0;
        error_segment_code <= ~code;
        error_class <= ~cls;
    endtask
    task automatic send_loss(input logic [4:0] pos);
        @(posedge mclk);
        arb_lost <= 1'b1;
        transmitting <= 1'b1;
        lost_bit_position <= pos;
        @(posedge mclk);
        arb_lost <= 1'b0;
        lost_bit_position <= ~pos;
    endtask
endmodule

// [test_can_error_arb_capture.sv]
`timescale 1ns/100ps
module test_can_error_arb_capture;
    import can_cap_pkg::*;
    logic mclk, rst_b, ce, bus_err, transmitting, arb_lost;
    logic [4:0] segment, lost;
    logic [1:0] cls, bresp, rresp;
    logic [7:0] tx_cnt, rx_cnt, last_err;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int err_count, check_count, cycles;
    can_bus_node u_node (.mclk(mclk), .bus_err(bus_err), .error_segment_code(segment), .error_class(cls),
        .transmitting(transmitting), .arb_lost(arb_lost), .lost_bit_position(lost));
    can_error_arb_capture u_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus_err(bus_err),
        .error_segment_code(segment), .error_class(cls), .transmitting(transmitting), .arb_lost(arb_lost),
        .lost_bit_position(lost), .tx_err_cnt(tx_cnt), .rx_err_cnt(rx_cnt), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ------------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        aw = 0; w = 0; b = 0;
        @(posedge mclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!b)
        begin
            @(negedge mclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            if (b) r = bresp;
            @(posedge mclk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
            if (b) bready <= 0;
        end
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, rr;
        ar = 0; rr = 0;
        @(posedge mclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!rr)
        begin
            @(negedge mclk);
            ar = arvalid && arready;
            rr = rvalid && rready;
            if (rr) d = rdata;
            if (rr) r = rresp;
            @(posedge mclk);
            if (ar) arvalid <= 0;
            if (rr) rready <= 0;
        end
    endtask
    // Reserved status bits are masked off before any comparison.
    task automatic read_status(input logic [31:0] exp, input string msg);
        logic [1:0] r;
        axi_read(STATUS_OFS, rd, r);
        check(rd & 32'h0003_ffff, exp, msg);
        check({30'h0, r}, {30'h0, RESP_OKAY}, "status resp");
    endtask
    function automatic logic [7:0] eb(input logic [4:0] s, input logic [1:0] c, input logic d);
        return {c, d, s};
    endfunction
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        read_status(32'h0, "idle status");
        u_node.send_err(5'h03, CLASS_FORM, 1'b0);
        u_node.send_loss(5'h04);
        read_status(32'h0, "events before start");
        check({24'h0, tx_cnt | rx_cnt}, 32'h0, "counters idle");
    endtask
    task automatic t_err_hold();
        logic [1:0] r;
        axi_write(CTRL_OFS, 32'h1, r);
        check({30'h0, r}, {30'h0, RESP_OKAY}, "ctrl write");
        u_node.send_err(5'd17, CLASS_STUFF, 1'b0);
        u_node.send_err(5'd8, CLASS_FORM, 1'b1);
        read_status({16'h1, 8'h0, eb(5'd17, CLASS_STUFF, DIR_RX)}, "first error held");
        check({rx_cnt, tx_cnt}, 16'h0101, "counters by direction");
        read_status({24'h0, eb(5'd17, CLASS_STUFF, DIR_RX)}, "repeat read");
        u_node.send_err(5'd2, CLASS_BIT, 1'b1);
        last_err = eb(5'd2, CLASS_BIT, DIR_TX);
        read_status({16'h1, 8'h0, last_err}, "rearmed after read");
    endtask
    task automatic t_arb();
        u_node.send_loss(5'd31);
        u_node.send_loss(5'd5);
        read_status({16'h2, 8'd31, last_err}, "first loss held");
        check({rx_cnt, tx_cnt}, 16'h0102, "loss not counted");
        u_node.send_loss(5'd0);
        u_node.send_err(5'd28, CLASS_OTHER, 1'b0);
        last_err = eb(5'd28, CLASS_OTHER, DIR_RX);
        read_status({16'h3, 8'd0, last_err}, "both fresh");
        read_status({16'h0, 8'd0, last_err}, "both cleared");
    endtask
    task automatic t_codes();
        logic [31:0] exp_w;
        logic [4:0] tbl [24] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15,
                                17, 18, 19, 22, 23, 24, 25, 26, 27, 28};
        for (int i = 0; i < 24; i++)
        begin
            u_node.send_err(tbl[i], 2'(i % 4), 1'(i % 2 == 0));
            exp_w = {16'h1, 8'h0, eb(tbl[i], 2'(i % 4), 1'(i % 2))};
            read_status(exp_w, "segment code");
        end
    endtask
    // An event seen while ce is low or communication is off must leave no trace.
    task automatic t_regs();
        logic [1:0]  r;
        logic [31:0] d;
        axi_read(TEC_OFS, d, r);
        check(d, 32'he, "transmit count read");
        axi_read(REC_OFS, d, r);
        check(d, 32'he, "receive count read");
        ce <= 1'b0;
        u_node.send_err(5'd9, CLASS_BIT, 1'b0);
        ce <= 1'b1;
        check({24'h0, rx_cnt}, 32'he, "frozen while ce low");
        read_status({24'h0, eb(5'd28, CLASS_OTHER, DIR_RX)}, "frozen event dropped");
        axi_write(CTRL_OFS, 32'h0, r);
        u_node.send_err(5'd9, CLASS_BIT, 1'b0);
        axi_read(CTRL_OFS, d, r);
        check(d, 32'h0, "comm disabled");
        check({24'h0, rx_cnt}, 32'he, "no count while disabled");
        axi_write(CTRL_OFS, 32'h1, r);
        read_status(32'h0, "restart clears");
        axi_read(4'h2, d, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
        check(d, 32'h0, "unmapped data");
        axi_write(4'h2, 32'h1, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    endtask
    // ------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end
    initial
    begin
        err_count = 0; check_count = 0; cycles = 0;
        rst_b = 0; ce = 1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1;
        @(posedge mclk);
        t_reset();
        t_err_hold();
        t_arb();
        t_codes();
        t_regs();
        give_verdict();
    end
endmodule
